// ### pkg/dus_pkg.sv
// constants and types shared by the dac update sequencer
// Summary of operation
// R1: six word-address bits plus space select split identification and io accesses
// R2: byte strobes choose low byte, high byte or full 16-bit write
// R3: identification space is read-only; io space is read and written
// R4: every access answers after one wait state, waveform data excepted
// R5: waveform memory data accesses answer after four wait states
// R6: one 16-bit shift register per converter channel, software visible
// R7: a trigger shifts all channels out together under shared counters
// R8: outputs change only on a trigger, never on a channel write
// R9: single-from-memory mode loads one memory value per channel per trigger
// R10: cycle-once mode steps through 2048 memory values, one per trigger
// R11: after the last cycle-once value, stop and request interrupt if enabled
// R12: continuous mode wraps memory and keeps converting on each trigger
// R13: 8-bit prescaler cascades into 16-bit conversion timer, 24 bits total
// R14: the prescaler counts cycles of the 8 MHz board clock
// R15: timer periods span from a few microseconds to about two seconds
// R16: every interval timer expiry is a conversion trigger
// R17: with external trigger enabled, its falling edge starts a conversion
// R18: select 01 means only external falling edges convert, one per edge
// R19: external source holds trigger low 250 ns to 6 us per edge
// R20: interrupt request goes low after a full memory cycle when enabled
// R21: an 8-bit vector is driven during interrupt acknowledge
// R22: the request is released during the acknowledge cycle
// R23: calibration byte ready shows as status bit 0, byte in bits 15:8
// R24: writing 0001h to start register 0eh is the software trigger
// R25: triggers arriving while a serial transfer runs are ignored
package dus_pkg;
	localparam int CLK_MHZ = 100;
	localparam int SCLK_HALF_NS = 50;
	localparam int SCLK_HALF_CYC = (SCLK_HALF_NS * CLK_MHZ + 999) / 1000;
	localparam int NUM_CH = 8;
	localparam int DAC_W = 16;
	localparam int WAVE_LEN = 2048;
	localparam int PRE_W = 8;
	localparam int CONV_W = 16;
	localparam int VEC_W = 8;
	localparam int AXI_AW = 9;
	localparam int ID_SPACE_BIT = 8;
	localparam int IDX_LSB = 2;
	localparam int IDX_W = 6;
	localparam logic [2:0] WAIT_STD = 3'h1;
	localparam logic [2:0] WAIT_WAVE = 3'h4;
	localparam logic [5:0] IDX_CTRL = 6'h00;
	localparam logic [5:0] IDX_PRESCALE = 6'h02;
	localparam logic [5:0] IDX_CONV = 6'h04;
	localparam logic [5:0] IDX_WAVE_DATA = 6'h06;
	localparam logic [5:0] IDX_WAVE_ADDR = 6'h08;
	localparam logic [5:0] IDX_CAL_ACCESS = 6'h0a;
	localparam logic [5:0] IDX_CAL_STATUS = 6'h0c;
	localparam logic [5:0] IDX_START = 6'h0e;
	localparam logic [5:0] IDX_DAC0 = 6'h10;
	localparam logic [5:0] IDX_VECTOR = 6'h20;
	localparam logic [5:0] ID_IDX_ASCII_END = 6'h04;
	localparam logic [5:0] ID_IDX_MANUF = 6'h04;
	localparam logic [5:0] ID_IDX_MODEL = 6'h05;
	localparam logic [31:0] ID_ASCII = 32'h64757331; // arbitrary id text
	localparam int CTRL_TRIG_LSB = 5;
	localparam int CTRL_IE_BIT = 7;
	localparam int CTRL_MODE_LSB = 8;
	localparam logic [1:0] TRIG_ALL = 2'h0;
	localparam logic [1:0] TRIG_EXT = 2'h1;
	localparam logic [1:0] TRIG_SWTMR = 2'h2;
	localparam logic [2:0] MODE_OFF = 3'h0;
	localparam logic [2:0] MODE_DAC_REG = 3'h1;
	localparam logic [2:0] MODE_MEM_SINGLE = 3'h2;
	localparam logic [2:0] MODE_MEM_ONCE = 3'h3;
	localparam logic [2:0] MODE_MEM_CONT = 3'h4;
	localparam logic [15:0] START_CMD = 16'h0001;
	localparam int STAT_DONE_BIT = 0;
	localparam int STAT_BUSY_BIT = 1;
	localparam int STAT_HALT_BIT = 2;
	localparam int CAL_BYTE_LSB = 8;
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [7:0] VEC_RST = 8'h00;
	localparam logic [2:0] SYNC_IDLE = 3'h6;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_SHIFT} dus_state_e;
endpackage

// ### design/dus_shift.sv
// simultaneous serial shifter feeding every converter channel
module dus_shift
	import dus_pkg::*;
#(
	parameter int NCH = NUM_CH,
	parameter int W = DAC_W,
	parameter int HALF = SCLK_HALF_CYC
)
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// parallel side
	input wire logic start,
	input wire logic [NCH*W-1:0] words,
	output logic busy,
	output logic done,
	// converter side
	output logic sclk,
	output logic [NCH-1:0] sdata,
	output logic load
);
	localparam int DW = $clog2(HALF + 1);
	localparam int BW = $clog2(W + 1);
	logic [W-1:0] sh [NCH];
	logic [DW-1:0] div;
	logic [BW-1:0] bits;

	// one divider and bit counter serve all channels so they stay in step
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			busy <= 1'b0;
			done <= 1'b0;
			load <= 1'b0;
			sclk <= 1'b0;
			div <= '0;
			bits <= '0;
			for (int c = 0; c < NCH; c++)
				sh[c] <= '0;
		end
		else
		begin
			done <= 1'b0;
			load <= 1'b0;
			if (!busy)
			begin
				if (start)
				begin
					busy <= 1'b1;
					bits <= BW'(W);
					div <= DW'(HALF - 1);
					for (int c = 0; c < NCH; c++)
						sh[c] <= words[c*W +: W]; // see R7
				end
			end
			else if (div != '0)
				div <= div - 1'b1;
			else
			begin
				div <= DW'(HALF - 1);
				sclk <= !sclk;
				if (sclk)
				begin
					for (int c = 0; c < NCH; c++)
						sh[c] <= {sh[c][W-2:0], 1'b0}; // see R7
					bits <= bits - 1'b1;
					if (bits == BW'(1))
					begin
						busy <= 1'b0;
						done <= 1'b1;
						load <= 1'b1; // see R7
					end
				end
			end
		end
	end

	always_comb
	begin
		for (int c = 0; c < NCH; c++)
			sdata[c] = sh[c][W-1];
	end
endmodule

// ### design/dus_top.sv
// dac update sequencer: register slave, trigger logic, waveform sequencing
module dus_top
	import dus_pkg::*;
#(
	parameter int NCH = NUM_CH,
	parameter int WLEN = WAVE_LEN,
	// arbitrary identification values
	parameter logic [7:0] ID_MANUF = 8'h5a,
	parameter logic [7:0] ID_MODEL = 8'h3c
)
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write
	input wire logic [AXI_AW-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read
	input wire logic [AXI_AW-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// board pins
	input wire logic board_clk,
	input wire logic ext_trig_n,
	// interrupt
	input wire logic int_ack_n,
	output logic int_req_n,
	output logic [VEC_W-1:0] ack_vector,
	output logic ack_vector_oe_n,
	// calibration memory
	output logic cal_req,
	output logic [15:0] cal_sel,
	input wire logic cal_done,
	input wire logic [7:0] cal_byte,
	// converters
	output logic dac_sclk,
	output logic [NCH-1:0] dac_sdata,
	output logic dac_load
);
	localparam int CH_W = $clog2(NCH);
	localparam int SMP_W = $clog2(WLEN);
	localparam int MEM_AW = CH_W + SMP_W;

	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] val, input logic [3:0] strb);
		logic [15:0] r;
		r = old;
		if (strb[0])
			r[7:0] = val[7:0];
		if (strb[1])
			r[15:8] = val[15:8];
		return r;
	endfunction

	function automatic logic is_dac(input logic [IDX_W-1:0] idx);
		return idx >= IDX_DAC0 && idx < IDX_DAC0 + IDX_W'(2 * NCH) && !idx[0];
	endfunction

	function automatic logic [CH_W-1:0] dac_ch(input logic [IDX_W-1:0] idx);
		return CH_W'((idx - IDX_DAC0) >> 1);
	endfunction

	function automatic logic [IDX_W-1:0] idx_of(input logic [AXI_AW-1:0] a);
		return a[IDX_LSB +: IDX_W];
	endfunction

	function automatic logic [2:0] waits(input logic [AXI_AW-1:0] a);
		if (!a[ID_SPACE_BIT] && idx_of(a) == IDX_WAVE_DATA)
			return WAIT_WAVE; // see R5
		return WAIT_STD; // see R4
	endfunction

	function automatic logic [1:0] resp_of(input logic [AXI_AW-1:0] a, input logic wr);
		logic [IDX_W-1:0] i;
		i = idx_of(a);
		if (a[ID_SPACE_BIT])
			return wr ? RESP_SLVERR : RESP_OKAY; // see R3
		else if (is_dac(i) || i == IDX_VECTOR || (i <= IDX_START && !i[0]))
			return RESP_OKAY;
		return RESP_SLVERR;
	endfunction

	logic [AXI_AW-1:0] aw_addr, ar_addr;
	logic aw_full, w_full, ar_full;
	logic [31:0] w_dat;
	logic [3:0] w_strb;
	logic wr_busy, rd_busy;
	logic [2:0] wr_cnt, rd_cnt;
	logic wr_fire, rd_fire, wr_io, rd_io;
	logic [IDX_W-1:0] wr_idx, rd_idx;
	logic [15:0] next_rdata;
	logic [15:0] ctrl, conv_reload, cal_access, stat;
	logic [PRE_W-1:0] pre_reload, pre_cnt;
	logic [CONV_W-1:0] conv_cnt;
	logic [VEC_W-1:0] vector;
	logic [15:0] dac_reg [NCH];
	logic [15:0] stage [NCH];
	logic [15:0] wave_mem [NCH*WLEN];
	logic [MEM_AW-1:0] wave_addr;
	logic [NCH*DAC_W-1:0] stage_flat;
	logic [2:0] pin_s1, pin_s2, pin_s3;
	logic board_tick, ext_fall, ack;
	logic cal_flag;
	logic [7:0] cal_data;
	logic ctrl_wr, cal_wr, wave_wr, wave_rd, sw_trig, tmr_fire, trig;
	logic sw_en, tmr_en, ext_en, trig_ok, once_end, halted;
	logic shift_go, shift_busy, shift_done;
	logic [1:0] trig_sel;
	logic [2:0] mode;
	dus_state_e state;
	logic [CH_W-1:0] fch;
	logic [SMP_W-1:0] sample;

	// write channel holding
	assign awready = !aw_full;
	assign wready = !w_full;
	assign wr_fire = wr_busy && wr_cnt == 3'h0;
	assign wr_io = !aw_addr[ID_SPACE_BIT]; // see R1
	assign wr_idx = idx_of(aw_addr); // see R1

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_full <= 1'b0;
			aw_addr <= '0;
		end
		else if (awvalid && awready)
		begin
			aw_full <= 1'b1;
			aw_addr <= awaddr;
		end
		else if (wr_fire)
			aw_full <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_full <= 1'b0;
			w_dat <= '0;
			w_strb <= '0;
		end
		else if (wvalid && wready)
		begin
			w_full <= 1'b1;
			w_dat <= wdata;
			w_strb <= wstrb;
		end
		else if (wr_fire)
			w_full <= 1'b0;
	end

	// wait-state counter, then the write takes effect and answers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wr_busy <= 1'b0;
			wr_cnt <= '0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end
		else
		begin
			if (bvalid && bready)
				bvalid <= 1'b0;
			if (wr_fire)
			begin
				wr_busy <= 1'b0;
				bvalid <= 1'b1;
				bresp <= resp_of(aw_addr, 1'b1);
			end
			else if (wr_busy)
				wr_cnt <= wr_cnt - 1'b1; // see R4
			else if (aw_full && w_full && !bvalid)
			begin
				wr_busy <= 1'b1;
				wr_cnt <= waits(aw_addr); // see R4
			end
		end
	end

	// read channel
	assign arready = !ar_full;
	assign rd_fire = rd_busy && rd_cnt == 3'h0;
	assign rd_io = !ar_addr[ID_SPACE_BIT]; // see R1
	assign rd_idx = idx_of(ar_addr);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ar_full <= 1'b0;
			ar_addr <= '0;
			rd_busy <= 1'b0;
			rd_cnt <= '0;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OKAY;
		end
		else
		begin
			if (rvalid && rready)
				rvalid <= 1'b0;
			if (arvalid && arready)
			begin
				ar_full <= 1'b1;
				ar_addr <= araddr;
			end
			if (rd_fire)
			begin
				ar_full <= 1'b0;
				rd_busy <= 1'b0;
				rvalid <= 1'b1;
				rdata <= 32'(next_rdata);
				rresp <= resp_of(ar_addr, 1'b0);
			end
			else if (rd_busy)
				rd_cnt <= rd_cnt - 1'b1; // see R5
			else if (ar_full && !rvalid)
			begin
				rd_busy <= 1'b1;
				rd_cnt <= waits(ar_addr); // see R4
			end
		end
	end

	always_comb
	begin
		stat = '0;
		stat[STAT_DONE_BIT] = cal_flag; // see R23
		stat[STAT_BUSY_BIT] = state != ST_IDLE;
		stat[STAT_HALT_BIT] = halted;
		stat[CAL_BYTE_LSB +: 8] = cal_data; // see R23
	end

	// identification space gives id bytes only; io space gives registers
	always_comb
	begin
		next_rdata = '0;
		if (!rd_io)
		begin
			if (rd_idx < ID_IDX_ASCII_END)
				next_rdata = 16'(8'(ID_ASCII >> {~rd_idx[1:0], 3'h0})); // see R3
			else if (rd_idx == ID_IDX_MANUF)
				next_rdata = 16'(ID_MANUF);
			else if (rd_idx == ID_IDX_MODEL)
				next_rdata = 16'(ID_MODEL);
		end
		else if (rd_idx == IDX_CTRL)
			next_rdata = ctrl;
		else if (rd_idx == IDX_PRESCALE)
			next_rdata = 16'(pre_reload);
		else if (rd_idx == IDX_CONV)
			next_rdata = conv_reload;
		else if (rd_idx == IDX_WAVE_DATA)
			next_rdata = wave_mem[wave_addr];
		else if (rd_idx == IDX_WAVE_ADDR)
			next_rdata = 16'(wave_addr);
		else if (rd_idx == IDX_CAL_ACCESS)
			next_rdata = cal_access;
		else if (rd_idx == IDX_CAL_STATUS)
			next_rdata = stat;
		else if (is_dac(rd_idx))
			next_rdata = dac_reg[dac_ch(rd_idx)]; // see R6
		else if (rd_idx == IDX_VECTOR)
			next_rdata = 16'(vector);
	end

	// write decode strobes and the wave data read strobe
	assign ctrl_wr = wr_fire && wr_io && wr_idx == IDX_CTRL;
	assign cal_wr = wr_fire && wr_io && wr_idx == IDX_CAL_ACCESS;
	assign wave_wr = wr_fire && wr_io && wr_idx == IDX_WAVE_DATA;
	assign wave_rd = rd_fire && rd_io && rd_idx == IDX_WAVE_DATA;
	assign sw_trig = wr_fire && wr_io && wr_idx == IDX_START
		&& merge16(16'h0000, w_dat, w_strb) == START_CMD; // see R24

	// register file; channel writes only stage data, outputs wait for a trigger
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl <= CTRL_RST;
			pre_reload <= '0;
			conv_reload <= '0;
			cal_access <= '0;
			vector <= VEC_RST;
			for (int c = 0; c < NCH; c++)
				dac_reg[c] <= '0;
		end
		else if (wr_fire && wr_io)
		begin
			if (wr_idx == IDX_CTRL)
				ctrl <= merge16(ctrl, w_dat, w_strb); // see R2
			else if (wr_idx == IDX_PRESCALE)
				pre_reload <= PRE_W'(merge16(16'(pre_reload), w_dat, w_strb));
			else if (wr_idx == IDX_CONV)
				conv_reload <= merge16(conv_reload, w_dat, w_strb);
			else if (wr_idx == IDX_CAL_ACCESS)
				cal_access <= merge16(cal_access, w_dat, w_strb);
			else if (is_dac(wr_idx))
				dac_reg[dac_ch(wr_idx)] <= merge16(dac_reg[dac_ch(wr_idx)],
					w_dat, w_strb); // see R8
			else if (wr_idx == IDX_VECTOR)
				vector <= VEC_W'(merge16(16'(vector), w_dat, w_strb));
		end
	end

	// waveform memory and its auto-advancing address
	always_ff @(posedge aclk)
	begin
		if (wave_wr)
			wave_mem[wave_addr] <= merge16(wave_mem[wave_addr], w_dat, w_strb);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			wave_addr <= '0;
		else if (wr_fire && wr_io && wr_idx == IDX_WAVE_ADDR)
			wave_addr <= MEM_AW'(merge16(16'(wave_addr), w_dat, w_strb));
		else if (wave_wr || wave_rd)
			wave_addr <= wave_addr + 1'b1;
	end

	// calibration byte fetch; a completion in the clearing cycle still sets
	assign cal_sel = cal_access;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cal_req <= 1'b0;
			cal_flag <= 1'b0;
			cal_data <= '0;
		end
		else
		begin
			cal_req <= cal_wr;
			if (cal_done)
			begin
				cal_flag <= 1'b1; // see R23
				cal_data <= cal_byte;
			end
			else if (cal_wr)
				cal_flag <= 1'b0;
		end
	end

	// pins are asynchronous; the second and third stages feed logic
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pin_s1 <= SYNC_IDLE;
			pin_s2 <= SYNC_IDLE;
			pin_s3 <= SYNC_IDLE;
		end
		else
		begin
			pin_s1 <= {int_ack_n, ext_trig_n, board_clk};
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
		end
	end

	assign board_tick = pin_s2[0] && !pin_s3[0]; // see R14
	assign ext_fall = !pin_s2[1] && pin_s3[1]; // see R17
	assign ack = !pin_s2[2];

	// trigger selection
	assign trig_sel = ctrl[CTRL_TRIG_LSB +: 2];
	assign mode = ctrl[CTRL_MODE_LSB +: 3];
	assign ext_en = trig_sel == TRIG_ALL || trig_sel == TRIG_EXT; // see R17
	assign sw_en = trig_sel != TRIG_EXT; // see R18
	assign tmr_en = (trig_sel == TRIG_ALL || trig_sel == TRIG_SWTMR) && mode != MODE_OFF;
	assign trig = (sw_trig && sw_en) || (tmr_fire && tmr_en) || (ext_fall && ext_en);

	// cascaded interval timer: period is (pre+1)*(conv+1) board clock cycles
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pre_cnt <= '0;
			conv_cnt <= '0;
			tmr_fire <= 1'b0;
		end
		else
		begin
			tmr_fire <= 1'b0;
			if (!tmr_en)
			begin
				pre_cnt <= pre_reload;
				conv_cnt <= conv_reload;
			end
			else if (board_tick)
			begin
				if (pre_cnt != '0)
					pre_cnt <= pre_cnt - 1'b1; // see R13
				else
				begin
					pre_cnt <= pre_reload; // see R15
					if (conv_cnt != '0)
						conv_cnt <= conv_cnt - 1'b1; // see R13
					else
					begin
						conv_cnt <= conv_reload;
						tmr_fire <= 1'b1; // see R16
					end
				end
			end
		end
	end

	// conversion sequencer; a trigger outside idle is dropped, not queued
	assign trig_ok = state == ST_IDLE && !shift_busy && !halted && mode != MODE_OFF; // see R25
	assign once_end = state == ST_SHIFT && shift_done && mode == MODE_MEM_ONCE
		&& sample == SMP_W'(WLEN - 1); // see R11

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state <= ST_IDLE;
			fch <= '0;
			sample <= '0;
			shift_go <= 1'b0;
			for (int c = 0; c < NCH; c++)
				stage[c] <= '0;
		end
		else
		begin
			shift_go <= 1'b0;
			case (state)
				ST_IDLE:
				begin
					if (trig && trig_ok)
					begin
						fch <= '0;
						if (mode == MODE_DAC_REG)
						begin
							for (int c = 0; c < NCH; c++)
								stage[c] <= dac_reg[c]; // see R8
							shift_go <= 1'b1;
							state <= ST_SHIFT;
						end
						else
							state <= ST_FETCH;
					end
				end
				ST_FETCH:
				begin
					stage[fch] <= wave_mem[{sample, fch}]; // see R9
					fch <= fch + 1'b1;
					if (fch == CH_W'(NCH - 1))
					begin
						shift_go <= 1'b1;
						state <= ST_SHIFT;
					end
				end
				ST_SHIFT:
				begin
					if (shift_done)
					begin
						state <= ST_IDLE;
						if (mode != MODE_DAC_REG)
							sample <= sample + 1'b1; // see R10 see R12
					end
				end
				default:
					state <= ST_IDLE;
			endcase
			if (ctrl_wr)
				sample <= '0;
		end
	end

	// halt after one pass; the set beats a same-cycle control write
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			halted <= 1'b0;
		else if (once_end)
			halted <= 1'b1; // see R11
		else if (ctrl_wr)
			halted <= 1'b0;
	end

	// release-on-acknowledge interrupt; vector driven while acknowledged
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			int_req_n <= 1'b1;
			ack_vector <= '0;
			ack_vector_oe_n <= 1'b1;
		end
		else
		begin
			if (once_end && ctrl[CTRL_IE_BIT])
				int_req_n <= 1'b0; // see R20
			else if (ack)
				int_req_n <= 1'b1; // see R22
			ack_vector <= vector; // see R21
			ack_vector_oe_n <= !ack; // see R21
		end
	end

	always_comb
	begin
		for (int c = 0; c < NCH; c++)
			stage_flat[c*DAC_W +: DAC_W] = stage[c];
	end

	dus_shift #(
		.NCH(NCH),
		.W(DAC_W),
		.HALF(SCLK_HALF_CYC)
	) u_shift (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(shift_go),
		.words(stage_flat),
		.busy(shift_busy),
		.done(shift_done),
		.sclk(dac_sclk),
		.sdata(dac_sdata),
		.load(dac_load)
	);
endmodule

// ### dv/dus_properties.sv
// port checker for the dac update sequencer
module dus_properties
	import dus_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// bus handshakes
	input wire logic [AXI_AW-1:0] awaddr,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic [AXI_AW-1:0] araddr,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	// pins
	input wire logic int_ack_n,
	input wire logic int_req_n,
	input wire logic ack_vector_oe_n,
	input wire logic cal_req,
	input wire logic dac_sclk,
	input wire logic dac_load
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic wr_go, rd_go;
	// bench offers aw and w together
	assign wr_go = awvalid && awready && wvalid && wready && !bvalid;
	assign rd_go = arvalid && arready && !rvalid;
	property p_wr_std;
		wr_go && awaddr[7:2] != IDX_WAVE_DATA |=> !bvalid ##1 !bvalid ##[1:2] bvalid;
	endproperty
	a_wr_std: assert property (p_wr_std) else $error("write answer late");
	property p_rd_std;
		rd_go && araddr[7:2] != IDX_WAVE_DATA |=> !rvalid ##1 !rvalid ##[1:2] rvalid;
	endproperty
	a_rd_std: assert property (p_rd_std) else $error("read answer late");
	property p_rd_wave;
		rd_go && araddr == 9'h018 |=> !rvalid [*5] ##[1:2] rvalid;
	endproperty
	a_rd_wave: assert property (p_rd_wave) else $error("wave read latency");
	property p_id_wr;
		wr_go && awaddr[ID_SPACE_BIT] |=> !bvalid ##1 !bvalid ##[1:2] (bvalid && bresp == RESP_SLVERR);
	endproperty
	a_id_wr: assert property (p_id_wr) else $error("id write accepted");
	property p_sclk;
		$changed(dac_sclk) |=> $stable(dac_sclk) [*4];
	endproperty
	a_sclk: assert property (p_sclk) else $error("serial clock pace");
	property p_load;
		dac_load |=> !dac_load [*8];
	endproperty
	a_load: assert property (p_load) else $error("load too soon");
	property p_irq;
		$fell(int_req_n) |-> $past(dac_load) || $past(dac_load, 2) || $past(dac_load, 3);
	endproperty
	a_irq: assert property (p_irq) else $error("request without cycle end");
	property p_release;
		!int_ack_n [*4] |-> int_req_n;
	endproperty
	a_release: assert property (p_release) else $error("request held in ack");
	property p_vec_on;
		!int_ack_n [*4] |-> !ack_vector_oe_n;
	endproperty
	a_vec_on: assert property (p_vec_on) else $error("vector not driven");
	property p_vec_off;
		int_ack_n [*4] |-> ack_vector_oe_n;
	endproperty
	a_vec_off: assert property (p_vec_off) else $error("vector driven idle");
	property p_cal;
		cal_req |=> !cal_req;
	endproperty
	a_cal: assert property (p_cal) else $error("cal request stuck");
endmodule

bind dus_top dus_properties u_props (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
	.awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp),
	.bvalid(bvalid), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
	.int_ack_n(int_ack_n), .int_req_n(int_req_n), .ack_vector_oe_n(ack_vector_oe_n),
	.cal_req(cal_req), .dac_sclk(dac_sclk), .dac_load(dac_load));

// ### dv/dus_far_model.sv
// converter bank and calibration memory behind the sequencer
module dus_far_model
	import dus_pkg::*;
#(
	parameter int CAL_LAT = 7
)
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// converters
	input wire logic dac_sclk,
	input wire logic [NUM_CH-1:0] dac_sdata,
	input wire logic dac_load,
	// calibration memory
	input wire logic cal_req,
	input wire logic [15:0] cal_sel,
	output logic cal_done,
	output logic [7:0] cal_byte,
	// observed results
	output logic [NUM_CH*DAC_W-1:0] dac_out,
	output logic [15:0] n_load
);
	timeunit 1ns;
	timeprecision 100ps;
	logic sclk_q;
	logic [NUM_CH*DAC_W-1:0] sh;
	logic [7:0] pend;
	int cnt;
	always_ff @(posedge aclk)
	begin
		sclk_q <= dac_sclk;
		if (!aresetn) n_load <= '0;
		// msb first, every channel on the same clock
		if (aresetn && dac_sclk && !sclk_q)
			for (int c = 0; c < NUM_CH; c++)
				sh[c*DAC_W +: DAC_W] <= {sh[c*DAC_W +: DAC_W-1], dac_sdata[c]};
		// outputs move only on the load strobe
		if (aresetn && dac_load)
		begin
			dac_out <= sh;
			n_load <= n_load + 16'h0001;
		end
	end
	always_ff @(posedge aclk)
	begin
		cal_done <= 1'b0;
		// byte lines toggle when not valid so stale data is never mistaken
		cal_byte <= ~cal_byte;
		if (!aresetn)
		begin
			cnt <= 0;
			cal_byte <= 8'h00;
		end
		else if (cal_req)
		begin
			cnt <= CAL_LAT;
			pend <= cal_sel[15:8] ^ 8'ha5;
		end
		else if (cnt == 1)
		begin
			cal_done <= 1'b1;
			cal_byte <= pend;
			cnt <= 0;
		end
		else if (cnt > 1) cnt <= cnt - 1;
	end
endmodule

// ### dv/testbench.sv
// self-checking bench for the dac update sequencer
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import dus_pkg::*;
	localparam int WL = 4;
	logic aclk = 1'b0, aresetn = 1'b0, board_clk = 1'b0;
	logic [8:0] awaddr, araddr;
	logic awvalid, wvalid, bready, arvalid, rready, ext_trig_n, int_ack_n, cal_done;
	logic awready, wready, bvalid, arready, rvalid, int_req_n, ack_vector_oe_n;
	logic cal_req, dac_sclk, dac_load;
	logic [31:0] wdata, rdata, rv;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rs;
	logic [7:0] ack_vector, cal_byte, dac_sdata;
	logic [15:0] cal_sel, n_load;
	logic [127:0] dac_out;
	int n_fail = 0, n_checks = 0, nl = 0, k;
	initial forever #5 aclk = ~aclk;
	initial #1 forever #62.5 board_clk = ~board_clk;
	// model id is arbitrary
	dus_top #(.WLEN(WL), .ID_MODEL(8'h77)) u_dut (.*);
	dus_far_model u_far (.*);
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic hung();
		n_fail++;
		tally_and_finish();
	endtask
	task automatic wr(input logic [8:0] a, input logic [15:0] d, input logic [3:0] s = 4'h3);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {16'h0000, d};
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge aclk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1 && n < 200);
		rs = bresp;
		bready <= 1'b0;
		if (bvalid !== 1'b1) hung();
	endtask
	task automatic rd(input logic [8:0] a);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge aclk);
			n++;
			if (arready) arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1 && n < 200);
		rv = rdata;
		rs = rresp;
		rready <= 1'b0;
		if (rvalid !== 1'b1) hung();
	endtask
	task automatic wait_loads();
		int n;
		for (n = 0; n < 2000 && n_load !== 16'(nl); n++) @(posedge aclk);
		if (n_load !== 16'(nl)) hung();
	endtask
	task automatic chk_out(input int b);
		for (int c = 0; c < NUM_CH; c++)
			chk({16'h0, dac_out[c*DAC_W +: DAC_W]}, 32'(b + c));
	endtask
	// software trigger, then one memory sample on every channel
	task automatic conv(input int s);
		wr(9'h038, START_CMD);
		nl++;
		wait_loads();
		chk_out(s * NUM_CH);
	endtask
	initial
	begin
		{awaddr, araddr, awvalid, wvalid, bready, arvalid, rready, wdata, wstrb} = '0;
		ext_trig_n = 1'b1;
		int_ack_n = 1'b1;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		for (k = 0; k < 4; k++)
		begin
			rd(9'h100 + 9'(4 * k));
			chk(rv, {24'h0, ID_ASCII[31-8*k -: 8]});
		end
		rd(9'h114);
		chk(rv, 32'h77);
		wr(9'h100, 16'hffff);
		chk(rs, RESP_SLVERR);
		rd(9'h100);
		chk(rv, {24'h0, ID_ASCII[31:24]});
		rd(9'h0fc);
		chk(rs, RESP_SLVERR);
		wr(9'h040, 16'h1234);
		wr(9'h040, 16'h00ab, 4'h1);
		wr(9'h040, 16'hcd00, 4'h2);
		rd(9'h040);
		chk(rv, 32'hcdab);
		$display("test bus decode done");
		wr(9'h000, 16'h0160);
		for (k = 0; k < NUM_CH; k++) wr(9'h040 + 9'(8 * k), 16'ha500 + 16'(k));
		repeat (300) @(posedge aclk);
		chk(n_load, 0);
		wr(9'h038, START_CMD);
		wr(9'h038, START_CMD);
		nl++;
		wait_loads();
		chk_out(16'ha500);
		repeat (300) @(posedge aclk);
		chk(n_load, nl);
		$display("test register update done");
		wr(9'h000, 16'h0120);
		wr(9'h038, START_CMD);
		repeat (300) @(posedge aclk);
		chk(n_load, nl);
		for (k = 0; k < 2; k++)
		begin
			ext_trig_n <= 1'b0;
			repeat (40) @(posedge aclk);
			ext_trig_n <= 1'b1;
			nl++;
			repeat (300) @(posedge aclk);
			chk(n_load, nl);
		end
		$display("test external trigger done");
		wr(9'h008, 16'h0001);
		wr(9'h010, 16'h0001);
		wr(9'h000, 16'h0140);
		nl++;
		wait_loads();
		chk_out(16'ha500);
		wr(9'h000, 16'h0160);
		repeat (400) @(posedge aclk);
		nl = n_load;
		$display("test timer done");
		wr(9'h020, 16'h0000);
		for (k = 0; k < WL * NUM_CH; k++) wr(9'h018, 16'(k));
		wr(9'h020, 16'h0005);
		rd(9'h018);
		chk(rv, 32'h5);
		wr(9'h080, 16'h005b);
		wr(9'h000, 16'h03e0);
		for (k = 0; k < WL; k++) conv(k);
		repeat (10) @(posedge aclk);
		chk(int_req_n, 1'b0);
		wr(9'h038, START_CMD);
		repeat (300) @(posedge aclk);
		chk(n_load, nl);
		int_ack_n <= 1'b0;
		repeat (6) @(posedge aclk);
		chk(ack_vector_oe_n, 1'b0);
		chk(ack_vector, 32'h5b);
		chk(int_req_n, 1'b1);
		int_ack_n <= 1'b1;
		wr(9'h000, 16'h0260);
		conv(0);
		conv(1);
		wr(9'h000, 16'h0460);
		for (k = 0; k <= WL; k++) conv(k % WL);
		$display("test waveform modes done");
		wr(9'h028, 16'h8200);
		rv = '0;
		for (k = 0; k < 50 && rv[0] !== 1'b1; k++) rd(9'h030);
		chk(rv[15:8], 32'h82 ^ 32'ha5);
		$display("test calibration done");
		tally_and_finish();
	end
	initial
	begin
		repeat (100000) @(posedge aclk);
		hung();
	end
endmodule
